// file: verilog/flash_seq_defines.vh
// Constants for the flash write and erase sequencer
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH
`define ADDR_TIMING 8'hab
`define ADDR_ADDR_LOW 8'hac
`define ADDR_ADDR_HIGH 8'had
`define ADDR_CMD 8'hae
`define ADDR_WDATA 8'haf
`define BIT_BUSY 7
`define BIT_WBUSY 6
`define BIT_CONT_READ 4
`define BIT_WRITE 1
`define BIT_ERASE 0
`define TIMING_RESET 8'h11
`define DMA_DMA_TRIGGER_SELECT_FLASH 5'h12
`define CLK_MHZ 250
`define TIMEOUT_US 40
`define TIMEOUT_CYCLES (`TIMEOUT_US * `CLK_MHZ)
`define TICKS_PER_UNIT 16
`define PROG_UNITS 1
`define ERASE_UNITS 1000
`define FIFO_DEPTH 8
`define TICK_LOAD 4'hf
`define TIMEOUT_LOAD 14'h270f
`define PROG_LOAD 10'h000
`define ERASE_LOAD 10'h3e7
`endif

// file: verilog/byte_fifo.v
// Byte FIFO between the write data port and the word assembler
`timescale 1ns/1ns
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    input wire flush,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire [AW:0] used = wr_q - rd_q;
    assign in_ready = (used != DEPTH[AW:0]);
    assign out_valid = (used != {(AW+1){1'b0}});
    assign out_data = mem[rd_q[AW-1:0]];
    always @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
    always @(posedge clk) begin
        if (sys_rst || flush) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && in_ready) begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // byte_fifo

// file: verilog/flash_write_erase_sequencer.v
// Flash write and page erase sequencer with register port and flash array port
`timescale 1ns/1ns
`include "flash_seq_defines.vh"
module flash_write_erase_sequencer (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_q,
    // DMA
    input wire [4:0] dma_trigger_select,
    output reg dma_trigger_q,
    // CPU flash access
    input wire cpu_flash_req,
    output reg cpu_stall_q,
    output reg access_violation_q,
    // Flash array
    output reg flash_prog_q,
    output reg flash_erase_q,
    output reg [13:0] flash_word_addr_q,
    output reg [15:0] flash_prog_data_q,
    output reg [4:0] flash_page_q
);
    localparam S_IDLE = 5'b00001;
    localparam S_ERASE = 5'b00010;
    localparam S_WAIT = 5'b00100;
    localparam S_PROG = 5'b01000;
    localparam S_LOW = 5'b10000;

    reg [4:0] state_q;
    reg [7:0] timing_q;
    reg [5:0] addr_high_q;
    reg [7:0] addr_low_q;
    reg cont_read_q;
    reg write_pend_q;
    reg [7:0] low_byte_q;
    reg [3:0] tick_div_q;
    reg [9:0] unit_cnt_q;
    reg [5:0] sub_cnt_q;
    reg [13:0] timeout_q;

    wire wr_cmd = reg_wr && (reg_addr == `ADDR_CMD);
    wire wr_data = reg_wr && (reg_addr == `ADDR_WDATA);
    wire flash_sel = (dma_trigger_select == `DMA_DMA_TRIGGER_SELECT_FLASH);
    wire busy = (state_q != S_IDLE);
    wire wbusy = (state_q == S_PROG);
    wire tick = (tick_div_q == 4'h0);
    wire fifo_in_ready;
    wire fifo_valid;
    wire [7:0] fifo_data;
    wire take = fifo_valid && ((state_q == S_WAIT) || (state_q == S_LOW));
    wire op_done = tick && (sub_cnt_q == 6'h00) && (unit_cnt_q == 10'h000);

    // Delay units less one, each unit being timing_q+1 tick blocks
    function [9:0] units;
        input is_erase;
        begin
            units = is_erase ? `ERASE_LOAD : `PROG_LOAD;
        end
    endfunction

    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(3)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .flush(state_q == S_IDLE),
        .in_valid(wr_data && (state_q != S_IDLE)),
        .in_ready(fifo_in_ready),
        .in_data(reg_wdata),
        .out_valid(fifo_valid),
        .out_ready(take),
        .out_data(fifo_data)
    );

    // Register writes
    always @(posedge clk) begin
        if (sys_rst) begin
            timing_q <= `TIMING_RESET;
            addr_high_q <= 6'h00;
            addr_low_q <= 8'h00;
            cont_read_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `ADDR_TIMING) begin
                timing_q <= {2'b00, reg_wdata[5:0]};
            end
            if (reg_wr && reg_addr == `ADDR_CMD) begin
                cont_read_q <= reg_wdata[`BIT_CONT_READ];
            end
            if (state_q == S_PROG && op_done) begin
                {addr_high_q, addr_low_q} <= {addr_high_q, addr_low_q} + 14'h0001;
            end else if (!busy && reg_wr && reg_addr == `ADDR_ADDR_HIGH) begin
                addr_high_q <= reg_wdata[5:0];
            end else if (!busy && reg_wr && reg_addr == `ADDR_ADDR_LOW) begin
                addr_low_q <= reg_wdata;
            end
        end
    end

    // Sequencer
    always @(posedge clk) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            write_pend_q <= 1'b0;
            low_byte_q <= 8'h00;
            tick_div_q <= 4'h0;
            unit_cnt_q <= 10'h000;
            sub_cnt_q <= 6'h00;
            timeout_q <= 14'h0000;
            flash_prog_q <= 1'b0;
            flash_erase_q <= 1'b0;
            flash_word_addr_q <= 14'h0000;
            flash_prog_data_q <= 16'hffff;
            flash_page_q <= 5'h00;
            dma_trigger_q <= 1'b0;
        end else begin
            tick_div_q <= tick ? `TICK_LOAD : tick_div_q - 4'h1;
            flash_prog_q <= 1'b0;
            flash_erase_q <= 1'b0;
            dma_trigger_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (wr_cmd && reg_wdata[`BIT_ERASE]) begin
                        state_q <= S_ERASE;
                        write_pend_q <= reg_wdata[`BIT_WRITE];
                        flash_page_q <= addr_high_q[5:1];
                        unit_cnt_q <= units(1'b1);
                        sub_cnt_q <= timing_q[5:0];
                    end else if (wr_cmd && reg_wdata[`BIT_WRITE]) begin
                        state_q <= S_WAIT;
                        timeout_q <= `TIMEOUT_LOAD;
                        dma_trigger_q <= flash_sel;
                    end
                end
                S_ERASE: begin
                    if (tick) begin
                        sub_cnt_q <= (sub_cnt_q == 6'h00) ? timing_q[5:0] : sub_cnt_q - 6'h01;
                        if (sub_cnt_q == 6'h00) begin
                            unit_cnt_q <= unit_cnt_q - 10'h001;
                        end
                    end
                    if (op_done) begin
                        flash_erase_q <= 1'b1;
                        write_pend_q <= 1'b0;
                        state_q <= write_pend_q ? S_WAIT : S_IDLE;
                        timeout_q <= `TIMEOUT_LOAD;
                        dma_trigger_q <= write_pend_q && flash_sel;
                    end
                end
                S_WAIT, S_LOW: begin
                    if (take && state_q == S_WAIT) begin
                        low_byte_q <= fifo_data;
                        state_q <= S_LOW;
                        dma_trigger_q <= flash_sel;
                    end else if (take) begin
                        flash_prog_data_q <= {fifo_data, low_byte_q};
                        flash_word_addr_q <= {addr_high_q, addr_low_q};
                        state_q <= S_PROG;
                        unit_cnt_q <= units(1'b0);
                        sub_cnt_q <= timing_q[5:0];
                    end else if (timeout_q == 14'h0000) begin
                        state_q <= S_IDLE;
                    end else begin
                        timeout_q <= timeout_q - 14'h0001;
                    end
                end
                S_PROG: begin
                    if (tick) begin
                        sub_cnt_q <= (sub_cnt_q == 6'h00) ? timing_q[5:0] : sub_cnt_q - 6'h01;
                        if (sub_cnt_q == 6'h00) begin
                            unit_cnt_q <= unit_cnt_q - 10'h001;
                        end
                    end
                    if (op_done) begin
                        flash_prog_q <= 1'b1;
                        state_q <= S_WAIT;
                        timeout_q <= `TIMEOUT_LOAD;
                        dma_trigger_q <= flash_sel;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // CPU access gating and read port
    always @(posedge clk) begin
        if (sys_rst) begin
            cpu_stall_q <= 1'b0;
            access_violation_q <= 1'b0;
            reg_rdata_q <= 8'h00;
        end else begin
            cpu_stall_q <= cpu_flash_req && busy;
            access_violation_q <= cpu_flash_req && wbusy;
            case (reg_addr)
                `ADDR_TIMING: reg_rdata_q <= timing_q;
                `ADDR_ADDR_LOW: reg_rdata_q <= addr_low_q;
                `ADDR_ADDR_HIGH: reg_rdata_q <= {2'b00, addr_high_q};
                `ADDR_CMD: reg_rdata_q <= {busy, wbusy, 1'b0, cont_read_q, 4'h0};
                `ADDR_WDATA: reg_rdata_q <= low_byte_q;
                default: reg_rdata_q <= 8'h00;
            endcase
        end
    end
endmodule // flash_write_erase_sequencer

// file: tb/flash_seq_chk.sv
// Port assertions for the flash write and erase sequencer
`timescale 1ns/1ns
`include "flash_seq_defines.vh"
module flash_seq_chk (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Register port and DMA
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [4:0] dma_trigger_select,
    input wire dma_trigger_q,
    // CPU and flash array
    input wire cpu_flash_req,
    input wire cpu_stall_q,
    input wire access_violation_q,
    input wire flash_prog_q,
    input wire flash_erase_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence write_cmd_s;
        reg_wr && reg_addr == `ADDR_CMD && reg_wdata == 8'h02 &&
            dma_trigger_select == `DMA_DMA_TRIGGER_SELECT_FLASH;
    endsequence
    sequence quiet_s;
        !flash_prog_q [*8] ##1 !flash_prog_q [*7];
    endsequence
    sequence pair_wait_s;
        !flash_prog_q [*4];
    endsequence
    first_dma_trigger_select_a: assert property (write_cmd_s |=> dma_trigger_q)
        else $error("no trigger after write command");
    dma_trigger_select_sel_a: assert property (dma_trigger_q |-> dma_trigger_select == `DMA_DMA_TRIGGER_SELECT_FLASH)
        else $error("trigger without flash source");
    dma_trigger_select_pulse_a: assert property (dma_trigger_q |=> !dma_trigger_q)
        else $error("trigger longer than one cycle");
    stall_cause_a: assert property (cpu_stall_q |-> $past(cpu_flash_req))
        else $error("stall without request");
    viol_cause_a: assert property (access_violation_q |-> $past(cpu_flash_req) && cpu_stall_q)
        else $error("violation without stalled request");
    prog_gap_a: assert property (flash_prog_q |=> quiet_s)
        else $error("word programmed too soon");
    erase_gap_a: assert property (flash_erase_q |=> !flash_prog_q [*8])
        else $error("program right after erase");
    cmd_gap_a: assert property (write_cmd_s |=> pair_wait_s)
        else $error("program before two bytes");
endmodule // flash_seq_chk
bind flash_write_erase_sequencer flash_seq_chk i_chk (.clk, .sys_rst, .reg_wr, .reg_addr,
    .reg_wdata, .dma_trigger_select, .dma_trigger_q, .cpu_flash_req, .cpu_stall_q,
    .access_violation_q, .flash_prog_q, .flash_erase_q);

// file: tb/dma_feeder.sv
// DMA channel model feeding the flash write data port
`timescale 1ns/1ns
module dma_feeder (
    // Clock and control
    input wire clk,
    input wire arm,
    input wire [3:0] count,
    // Trigger and transfer
    input wire dma_trigger_q,
    output reg dma_wr = 1'b0,
    output reg [7:0] dma_wdata = 8'h00
);
    reg [3:0] sent_q = 4'h0;
    // One byte per trigger, source advancing, fixed destination
    always @(negedge clk) begin
        dma_wr <= 1'b0;
        dma_wdata <= ~dma_wdata;
        if (!arm) begin
            sent_q <= 4'h0;
        end else if (dma_trigger_q && sent_q < count) begin
            dma_wr <= 1'b1;
            dma_wdata <= {4'ha, sent_q};
            sent_q <= sent_q + 4'h1;
        end
    end
endmodule // dma_feeder

// file: tb/flash_write_erase_sequencer_bench.sv
// Self-checking bench for the flash write and erase sequencer
`timescale 1ns/1ns
`include "flash_seq_defines.vh"
`define CHK(nm, exp, got) samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end
module flash_write_erase_sequencer_bench;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg tb_wr = 1'b0;
    reg [7:0] tb_addr = 8'h00;
    reg [7:0] tb_wdata = 8'h00;
    reg cpu_flash_req = 1'b0;
    reg arm = 1'b0;
    reg [3:0] count = 4'h0;
    reg saw_viol = 1'b0;
    integer errors = 0;
    integer samples_checked = 0;
    wire dma_wr, dma_trigger_q, cpu_stall_q, access_violation_q, flash_prog_q, flash_erase_q;
    wire [7:0] dma_wdata, reg_rdata_q;
    wire [13:0] flash_word_addr_q;
    wire [15:0] flash_prog_data_q;
    wire [4:0] flash_page_q;
    // Bench stands in for RAM-resident software
    flash_write_erase_sequencer i_dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(tb_wr | dma_wr),
        .reg_rd(1'b0), .reg_addr(dma_wr ? `ADDR_WDATA : tb_addr),
        .reg_wdata(dma_wr ? dma_wdata : tb_wdata), .reg_rdata_q(reg_rdata_q),
        .dma_trigger_select(`DMA_DMA_TRIGGER_SELECT_FLASH), .dma_trigger_q(dma_trigger_q),
        .cpu_flash_req(cpu_flash_req), .cpu_stall_q(cpu_stall_q),
        .access_violation_q(access_violation_q), .flash_prog_q(flash_prog_q),
        .flash_erase_q(flash_erase_q), .flash_word_addr_q(flash_word_addr_q),
        .flash_prog_data_q(flash_prog_data_q), .flash_page_q(flash_page_q));
    dma_feeder i_dma (.clk(clk), .arm(arm), .count(count), .dma_trigger_q(dma_trigger_q),
        .dma_wr(dma_wr), .dma_wdata(dma_wdata));
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (access_violation_q === 1'b1) saw_viol = 1'b1;
    task results;
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(negedge clk);
        tb_wr = 1'b1;
        tb_addr = a;
        tb_wdata = d;
        @(negedge clk);
        tb_wr = 1'b0;
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(negedge clk);
        tb_addr = a;
        @(negedge clk);
        d = reg_rdata_q;
    endtask
    task wait_pulse(input erase, input integer lim);
        integer n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((erase ? flash_erase_q : flash_prog_q) !== 1'b1 && n < lim);
        if (n >= lim) begin
            errors++;
            results;
        end
    endtask
    task check_reset;
        reg [7:0] d;
        rd(`ADDR_TIMING, d);
        `CHK("timing", `TIMING_RESET, d)
        rd(`ADDR_CMD, d);
        `CHK("command", 8'h00, d)
        wr(`ADDR_TIMING, 8'h00);
        rd(`ADDR_TIMING, d);
        `CHK("timing written", 8'h00, d)
    endtask
    task dma_write;
        reg [7:0] d;
        wr(`ADDR_ADDR_HIGH, 8'h05);
        wr(`ADDR_ADDR_LOW, 8'hff);
        count = 4'h4;
        arm = 1'b1;
        wr(`ADDR_CMD, 8'h02);
        wait_pulse(1'b0, 200);
        `CHK("addr 0", 14'h05ff, flash_word_addr_q)
        `CHK("data 0", 16'ha1a0, flash_prog_data_q)
        wait_pulse(1'b0, 200);
        `CHK("addr 1", 14'h0600, flash_word_addr_q)
        `CHK("data 1", 16'ha3a2, flash_prog_data_q)
        rd(`ADDR_CMD, d);
        `CHK("busy in write", 1'b1, d[`BIT_BUSY])
        `CHK("word busy low", 1'b0, d[`BIT_WBUSY])
        repeat (`TIMEOUT_CYCLES + 50) @(negedge clk);
        arm = 1'b0;
        rd(`ADDR_CMD, d);
        `CHK("busy after timeout", 1'b0, d[`BIT_BUSY])
        rd(`ADDR_ADDR_LOW, d);
        `CHK("held addr", 8'h01, d)
    endtask
    task erase_write;
        reg [7:0] d;
        wr(`ADDR_ADDR_HIGH, 8'h02);
        wr(`ADDR_ADDR_LOW, 8'h00);
        count = 4'h2;
        arm = 1'b1;
        wr(`ADDR_CMD, 8'h03);
        cpu_flash_req = 1'b1; // CPU flash request held from the erase command on
        rd(`ADDR_CMD, d);
        `CHK("busy in erase", 1'b1, d[`BIT_BUSY])
        `CHK("stall", 1'b1, cpu_stall_q)
        wait_pulse(1'b1, 20000);
        `CHK("erase page", 5'h01, flash_page_q)
        `CHK("no violation in erase", 1'b0, saw_viol)
        wait_pulse(1'b0, 200);
        `CHK("addr after erase", 14'h0200, flash_word_addr_q)
        `CHK("data after erase", 16'ha1a0, flash_prog_data_q)
        `CHK("violation", 1'b1, saw_viol)
        repeat (`TIMEOUT_CYCLES + 50) @(negedge clk);
        arm = 1'b0;
        repeat (2) @(negedge clk);
        arm = 1'b1;
        wr(`ADDR_CMD, 8'h02);
        wait_pulse(1'b0, 200);
        `CHK("resumed addr", 14'h0201, flash_word_addr_q)
        cpu_flash_req = 1'b0;
        arm = 1'b0;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        check_reset;
        dma_write;
        erase_write;
        results;
    end
endmodule // flash_write_erase_sequencer_bench
